// [hw/cmr_core_regs.sv]
// Core register file and privilege/mode state of a 32-bit embedded core.
// Assumes the pipeline drives the core-side ports from the same clock and
// that software reaches the special registers over the plain register port.
//
// Functional notes
// - Handler mode exists only at privileged level.
// - User access to special registers faults.
// - Handler mode during exceptions, thread otherwise.
// - Sixteen 32-bit core registers.
// - Narrow instructions cannot always reach high registers.
// - Process stack only in user thread.
// - Stack pointer low two bits forced zero.
// - Subroutine call stores return address in link.
// - Instruction pointer bit zero forced zero.
// - Status word built from three parts.
// - Result flags in top five bits.
// - Active exception number in low nine bits.
// - Continuation state at bits 10-15, 25-26.
// - Bit 24 stays one; clearing attempt faults.
// - Mask-all passes only NMI and hard fault.
// - Fault mask passes only NMI.
// - Priority threshold blocks equal or lower urgency.
// - Control bit 0 selects user thread.
// - Control bit 1 selects alternate stack.
// - Mixed 16/32-bit encodings; no legacy set.
// - Bit-band alias gives atomic SRAM bit access.
`timescale 1ns/100ps

module cmr_core_regs
    import cmr_pkg::*;
#(
    parameter int PRIO_W = PRIO_BITS
)
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    input  wire logic [AW-1:0]     i_reg_addr,
    input  wire logic [XLEN-1:0]   i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [XLEN-1:0]   o_reg_rdata,
    input  wire logic              i_rf_rd,
    input  wire logic [3:0]        i_rf_raddr,
    output logic      [XLEN-1:0]   o_rf_rdata,
    input  wire logic              i_rf_we,
    input  wire logic [3:0]        i_rf_waddr,
    input  wire logic [XLEN-1:0]   i_rf_wdata,
    input  wire logic              i_rf_narrow,
    input  wire logic              i_rf_hi_ok,
    input  wire logic              i_call,
    input  wire logic [XLEN-1:0]   i_call_ret,
    input  wire logic              i_pc_load,
    input  wire logic [XLEN-1:0]   i_pc_next,
    input  wire logic              i_pc_interwork,
    input  wire logic              i_flags_we,
    input  wire logic [FLAG_W-1:0] i_flags,
    input  wire logic              i_exec_we,
    input  wire logic [EXEC_W-1:0] i_exec_state,
    input  wire logic              i_exc_entry,
    input  wire logic              i_exc_return,
    input  wire logic [EXC_W-1:0]  i_exc_num,
    input  wire logic              i_irq_req,
    input  wire logic [EXC_W-1:0]  i_irq_num,
    input  wire logic [PRIO_W-1:0] i_irq_prio,
    input  wire logic [15:0]       i_fetch_hw,
    input  wire logic [XLEN-1:0]   i_bb_addr,
    output logic      [XLEN-1:0]   o_instr_pointer,
    output logic                   o_handler_mode,
    output logic                   o_user_level,
    output logic                   o_irq_take,
    output logic      [EXC_W-1:0]  o_irq_take_num,
    output logic                   o_fault,
    output logic      [2:0]        o_fault_cause,
    output logic                   o_instr_wide,
    output logic                   o_bb_hit,
    output logic      [XLEN-1:0]   o_bb_word_addr,
    output logic      [4:0]        o_bb_bit
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    cmr_mode_t              mode_q;
    cmr_mode_t              mode_d;
    logic [XLEN-1:0]        gpr_q [GPR_CNT];
    logic [XLEN-1:0]        msp_q;
    logic [XLEN-1:0]        psp_q;
    logic [XLEN-1:0]        lr_q;
    logic [XLEN-1:0]        pc_q;
    logic [FLAG_W-1:0]      flags_q;
    logic [EXEC_W-1:0]      exec_q;
    logic [EXC_W-1:0]       exc_q;
    logic                   maskall_q;
    logic                   fltmask_q;
    logic [PRIO_W-1:0]      prio_thr_q;
    logic [1:0]             ctrl_q;
    logic [XLEN-1:0]        reg_rdata_q;
    logic [XLEN-1:0]        rf_rdata_q;
    logic                   irq_take_q;
    logic [EXC_W-1:0]       irq_take_num_q;
    logic                   fault_q;
    cmr_fault_t             fault_cause_q;
    logic                   wide_q;
    logic                   bb_hit_q;
    logic [XLEN-1:0]        bb_word_q;
    logic [4:0]             bb_bit_q;

    ////////////////////////////////////////////////////////////////////////
    // Mode and privilege.
    wire is_handler = mode_q[MODE_HND_BIT];
    wire is_user    = mode_q[MODE_USR_BIT];
    // The process stack serves as SP only for user thread code; privileged
    // code always works on the main stack so a corrupt task stack cannot
    // take down the kernel.
    wire use_psp    = is_user & ctrl_q[CTL_ALT];

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode.
    wire addr_core  = (i_reg_addr <= OFS_CORE_LAST);
    wire [3:0] addr_idx = i_reg_addr[5:2];
    wire hit_psw    = (i_reg_addr == OFS_PSW);
    wire hit_flags  = (i_reg_addr == OFS_FLAGS);
    wire hit_excnum = (i_reg_addr == OFS_EXCNUM);
    wire hit_exec   = (i_reg_addr == OFS_EXEC);
    wire hit_mall   = (i_reg_addr == OFS_MASKALL);
    wire hit_fmask  = (i_reg_addr == OFS_FLTMASK);
    wire hit_prio   = (i_reg_addr == OFS_PRIOTHR);
    wire hit_ctrl   = (i_reg_addr == OFS_CTRL);
    wire hit_msp    = (i_reg_addr == OFS_MSP);
    wire hit_psp    = (i_reg_addr == OFS_PSP);
    wire hit_spec   = hit_psw | hit_excnum | hit_exec | hit_mall | hit_fmask
                    | hit_prio | hit_ctrl | hit_msp | hit_psp;

    // User code may touch core registers and the result flags only.
    wire priv_viol  = is_user & hit_spec & (i_reg_wr | i_reg_rd);
    wire spec_wr    = i_reg_wr & ~is_user;
    wire exec_wr    = spec_wr & (hit_psw | hit_exec);
    wire tbit_clear = exec_wr & ~i_reg_wdata[PSW_TBIT];
    // A branch that asks for the legacy full-width set faults, but the PC still loads.
    wire iw_clear   = i_pc_load & i_pc_interwork & ~i_pc_next[0];
    wire bus_core_wr = i_reg_wr & addr_core;

    ////////////////////////////////////////////////////////////////////////
    // Core-side port checks.
    wire rd_hi  = (i_rf_raddr >= IDX_HI_LOW) & (i_rf_raddr <= IDX_HI_HIGH);
    wire wr_hi  = (i_rf_waddr >= IDX_HI_LOW) & (i_rf_waddr <= IDX_HI_HIGH);
    wire hi_bad_rd = i_rf_rd & i_rf_narrow & ~i_rf_hi_ok & rd_hi;
    wire hi_bad_wr = i_rf_we & i_rf_narrow & ~i_rf_hi_ok & wr_hi;
    wire core_wr   = i_rf_we & ~hi_bad_wr;

    ////////////////////////////////////////////////////////////////////////
    // Program status word, assembled from its three parts.
    logic [XLEN-1:0] psw_w;
    always_comb
    begin
        psw_w = '0;
        psw_w[PSW_FLAG_MSB:PSW_FLAG_LSB] = flags_q;
        psw_w[PSW_ITH_MSB:PSW_ITH_LSB] = exec_q[EXEC_W-1:EXEC_ITL_W];
        psw_w[PSW_TBIT]                  = 1'b1;
        psw_w[PSW_ITL_MSB:PSW_ITL_LSB]   = exec_q[EXEC_ITL_W-1:0];
        psw_w[PSW_EXC_MSB:0]             = exc_q;
    end

    wire [XLEN-1:0] psw_flags_v = psw_w & {{FLAG_W{1'b1}},
                                           {(XLEN-FLAG_W){1'b0}}};
    wire [XLEN-1:0] psw_exc_v   = {{(XLEN-EXC_W){1'b0}}, exc_q};
    wire [XLEN-1:0] psw_exec_v  = psw_w & ~psw_flags_v & ~psw_exc_v;
    wire [EXEC_W-1:0] bus_exec  = {i_reg_wdata[PSW_ITH_MSB:PSW_ITH_LSB],
                                   i_reg_wdata[PSW_ITL_MSB:PSW_ITL_LSB]};

    ////////////////////////////////////////////////////////////////////////
    // Core register read view.
    function automatic logic [XLEN-1:0] core_view(input logic [3:0] idx);
        logic [XLEN-1:0] v;
        if (idx == IDX_SP)
            v = use_psp ? psp_q : msp_q;
        else if (idx == IDX_LR)
            v = lr_q;
        else if (idx == IDX_PC)
            v = pc_q;
        else
            v = gpr_q[idx];
        return v;
    endfunction : core_view

    wire [XLEN-1:0] spec_view =
          hit_psw    ? psw_w
        : hit_excnum ? psw_exc_v
        : hit_exec   ? psw_exec_v
        : hit_mall   ? {{(XLEN-1){1'b0}}, maskall_q}
        : hit_fmask  ? {{(XLEN-1){1'b0}}, fltmask_q}
        : hit_prio   ? {{(XLEN-PRIO_W){1'b0}}, prio_thr_q}
        : hit_ctrl   ? {{(XLEN-2){1'b0}}, ctrl_q}
        : hit_msp    ? msp_q
        : hit_psp    ? psp_q
        : '0;

    // Unmapped offsets and blocked special reads answer zero.
    wire [XLEN-1:0] bus_view =
          addr_core ? core_view(addr_idx)
        : hit_flags ? psw_flags_v
        : is_user   ? '0
        : spec_view;

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer and link register next values.
    wire sp_core_wr = core_wr & (i_rf_waddr == IDX_SP);
    wire sp_bus_wr  = bus_core_wr & (addr_idx == IDX_SP);
    wire [XLEN-1:0] sp_new = sp_core_wr ? i_rf_wdata : i_reg_wdata;
    wire [XLEN-1:0] sp_aln = {sp_new[XLEN-1:2], 2'b00};
    wire sp_wr     = sp_core_wr | sp_bus_wr;
    wire msp_wr    = (sp_wr & ~use_psp) | (spec_wr & hit_msp);
    wire psp_wr    = (sp_wr & use_psp) | (spec_wr & hit_psp);
    wire [XLEN-1:0] msp_d = sp_wr ? sp_aln : {i_reg_wdata[XLEN-1:2], 2'b00};
    wire [XLEN-1:0] psp_d = msp_d;

    wire [XLEN-1:0] lr_d =
          i_call                            ? i_call_ret
        : (core_wr & (i_rf_waddr == IDX_LR)) ? i_rf_wdata
        : (bus_core_wr & (addr_idx == IDX_LR)) ? i_reg_wdata
        : lr_q;

    wire [XLEN-1:0] pc_src =
          i_pc_load                          ? i_pc_next
        : (core_wr & (i_rf_waddr == IDX_PC)) ? i_rf_wdata
        : (bus_core_wr & (addr_idx == IDX_PC)) ? i_reg_wdata
        : pc_q;
    wire [XLEN-1:0] pc_d = {pc_src[XLEN-1:1], 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Exception number, control and mode sequencing.
    wire [EXC_W-1:0] exc_d = (i_exc_entry | i_exc_return) ? i_exc_num
                                                          : exc_q;
    wire [1:0] ctrl_w = {i_reg_wdata[CTL_ALT] & ~is_handler,
                         i_reg_wdata[CTL_USER]};
    wire [1:0] ctrl_d = (spec_wr & hit_ctrl) ? ctrl_w : ctrl_q;
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_PRIV_THREAD:
                if (i_exc_entry)
                    mode_d = MODE_PRIV_HANDLER;
                else if (ctrl_d[CTL_USER])
                    mode_d = MODE_USER_THREAD;
            MODE_USER_THREAD:
                if (i_exc_entry)
                    mode_d = MODE_PRIV_HANDLER;
            MODE_PRIV_HANDLER:
                if (i_exc_return & (i_exc_num == EXC_NONE))
                    mode_d = cmr_mode_t'(ctrl_q[CTL_USER] ? MODE_USER_THREAD
                                              : MODE_PRIV_THREAD);
            default:
                mode_d = MODE_PRIV_THREAD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt acceptance against the three masks.
    wire thr_pass  = (prio_thr_q == '0) | (i_irq_prio < prio_thr_q);
    wire irq_ok    = (i_irq_num == EXC_NMI)
                   | ((i_irq_num == EXC_HARD) & ~fltmask_q)
                   | (~fltmask_q & ~maskall_q & thr_pass);

    ////////////////////////////////////////////////////////////////////////
    // Fault reporting.
    wire cmr_fault_t fault_d = cmr_fault_t'(
          priv_viol                ? FLT_PRIV
        : (tbit_clear | iw_clear)  ? FLT_TBIT
        : (hi_bad_rd | hi_bad_wr)  ? FLT_HIREG
        : FLT_NONE);

    ////////////////////////////////////////////////////////////////////////
    // Instruction width and bit-band translation.
    wire wide_d = (i_fetch_hw[15:13] == WIDE_PFX)
                & (i_fetch_hw[12:11] != WIDE_NOT);
    wire bb_hit_d = ((i_bb_addr & BB_ALIAS_MASK) == BB_ALIAS_BASE);
    wire [XLEN-1:0] bb_byte = BB_SRAM_BASE
                            + {7'h00, i_bb_addr[24:0] >> 7};
    wire [XLEN-1:0] bb_word_d = {bb_byte[XLEN-1:2], 2'b00};
    wire [4:0] bb_bit_d = {bb_byte[1:0], i_bb_addr[4:2]};

    ////////////////////////////////////////////////////////////////////////
    // General registers, one write decoder per entry.
    genvar gi;
    generate
        for (gi = 0; gi < GPR_CNT; gi++)
        begin : g_gpr
            localparam logic [3:0] IDX = 4'(gi);
            wire core_hit = core_wr & (i_rf_waddr == IDX);
            wire bus_hit  = bus_core_wr & (addr_idx == IDX);
            always_ff @(posedge i_ref_clk)
            begin
                if (i_srst)
                    gpr_q[gi] <= '0;
                else if (core_hit)
                    gpr_q[gi] <= i_rf_wdata;
                else if (bus_hit)
                    gpr_q[gi] <= i_reg_wdata;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Special registers and mode.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            mode_q     <= MODE_PRIV_THREAD;
            msp_q      <= '0;
            psp_q      <= '0;
            lr_q       <= '0;
            pc_q       <= '0;
            flags_q    <= '0;
            exec_q     <= '0;
            exc_q      <= EXC_NONE;
            maskall_q  <= 1'b0;
            fltmask_q  <= 1'b0;
            prio_thr_q <= '0;
            ctrl_q     <= 2'h0;
        end
        else
        begin
            mode_q <= mode_d;
            if (msp_wr)
                msp_q <= msp_d;
            if (psp_wr)
                psp_q <= psp_d;
            lr_q   <= lr_d;
            pc_q   <= pc_d;
            exc_q  <= exc_d;
            ctrl_q <= ctrl_d;
            if (i_flags_we)
                flags_q <= i_flags;
            else if (i_reg_wr & (hit_flags | (hit_psw & ~is_user)))
                flags_q <= i_reg_wdata[PSW_FLAG_MSB:PSW_FLAG_LSB];
            // A status write that would clear the state bit leaves the execution state; a PSW write still sets flags.
            if (i_exec_we)
                exec_q <= i_exec_state;
            else if (exec_wr & ~tbit_clear)
                exec_q <= bus_exec;
            if (spec_wr & hit_mall)
                maskall_q <= i_reg_wdata[0];
            if (spec_wr & hit_fmask)
                fltmask_q <= i_reg_wdata[0];
            if (spec_wr & hit_prio)
                prio_thr_q <= i_reg_wdata[PRIO_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered answers.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            reg_rdata_q    <= '0;
            rf_rdata_q     <= '0;
            irq_take_q     <= 1'b0;
            irq_take_num_q <= EXC_NONE;
            fault_q        <= 1'b0;
            fault_cause_q  <= FLT_NONE;
            wide_q         <= 1'b0;
            bb_hit_q       <= 1'b0;
            bb_word_q      <= '0;
            bb_bit_q       <= 5'h00;
        end
        else
        begin
            reg_rdata_q    <= i_reg_rd ? bus_view : '0;
            rf_rdata_q     <= hi_bad_rd ? '0 : core_view(i_rf_raddr);
            irq_take_q     <= i_irq_req & irq_ok;
            irq_take_num_q <= i_irq_num;
            fault_q        <= (fault_d != FLT_NONE);
            fault_cause_q  <= fault_d;
            wide_q         <= wide_d;
            bb_hit_q       <= bb_hit_d;
            bb_word_q      <= bb_word_d;
            bb_bit_q       <= bb_bit_d;
        end
    end

    assign o_reg_rdata    = reg_rdata_q;
    assign o_rf_rdata     = rf_rdata_q;
    assign o_instr_pointer = pc_q;
    assign o_handler_mode = mode_q[MODE_HND_BIT];
    assign o_user_level   = mode_q[MODE_USR_BIT];
    assign o_irq_take     = irq_take_q;
    assign o_irq_take_num = irq_take_num_q;
    assign o_fault        = fault_q;
    assign o_fault_cause  = fault_cause_q;
    assign o_instr_wide   = wide_q;
    assign o_bb_hit       = bb_hit_q;
    assign o_bb_word_addr = bb_word_q;
    assign o_bb_bit       = bb_bit_q;

endmodule : cmr_core_regs

// [shared/cmr_pkg.sv]
// Constants for the core register and mode block: register map, field
// positions, reset values and the mode state encoding.
// Assumes one core clock domain and a synchronous active-high reset.
package cmr_pkg;

    localparam int XLEN      = 32;
    localparam int GPR_CNT   = 13;
    localparam int EXC_W     = 9;
    localparam int PRIO_BITS = 9;
    localparam int FLAG_W    = 5;
    localparam int EXEC_W    = 8;
    localparam int AW        = 8;

    // Core register indices on the core-side ports.
    localparam logic [3:0] IDX_SP      = 4'hd;
    localparam logic [3:0] IDX_LR      = 4'he;
    localparam logic [3:0] IDX_PC      = 4'hf;
    localparam logic [3:0] IDX_HI_LOW  = 4'h8;
    localparam logic [3:0] IDX_HI_HIGH = 4'hc;

    // Register bus byte offsets; 0x00 to 0x3c are the sixteen core registers.
    localparam logic [AW-1:0] OFS_CORE_LAST = 8'h3c;
    localparam logic [AW-1:0] OFS_PSW       = 8'h40;
    localparam logic [AW-1:0] OFS_FLAGS     = 8'h44;
    localparam logic [AW-1:0] OFS_EXCNUM    = 8'h48;
    localparam logic [AW-1:0] OFS_EXEC      = 8'h4c;
    localparam logic [AW-1:0] OFS_MASKALL   = 8'h50;
    localparam logic [AW-1:0] OFS_FLTMASK   = 8'h54;
    localparam logic [AW-1:0] OFS_PRIOTHR   = 8'h58;
    localparam logic [AW-1:0] OFS_CTRL      = 8'h5c;
    localparam logic [AW-1:0] OFS_MSP       = 8'h60;
    localparam logic [AW-1:0] OFS_PSP       = 8'h64;

    // Program status word field positions.
    localparam int PSW_FLAG_LSB = 27;
    localparam int PSW_FLAG_MSB = 31;
    localparam int PSW_ITH_LSB  = 25;
    localparam int PSW_ITH_MSB  = 26;
    localparam int PSW_TBIT     = 24;
    localparam int PSW_ITL_LSB  = 10;
    localparam int PSW_ITL_MSB  = 15;
    localparam int PSW_EXC_MSB  = 8;
    localparam int EXEC_ITL_W   = 6;

    // Mode control bits.
    localparam int CTL_USER = 0;
    localparam int CTL_ALT  = 1;

    localparam logic [EXC_W-1:0] EXC_NONE = 9'h000;
    localparam logic [EXC_W-1:0] EXC_NMI  = 9'h002;
    localparam logic [EXC_W-1:0] EXC_HARD = 9'h003;

    // A 32-bit encoding starts with a halfword whose top bits are 111 and
    // whose next two bits are not 00.
    localparam logic [2:0] WIDE_PFX  = 3'h7;
    localparam logic [1:0] WIDE_NOT  = 2'h0;

    // Bit-band alias window and the SRAM region it maps onto.
    localparam logic [XLEN-1:0] BB_ALIAS_BASE = 32'h2200_0000;
    localparam logic [XLEN-1:0] BB_ALIAS_MASK = 32'hfe00_0000;
    localparam logic [XLEN-1:0] BB_SRAM_BASE  = 32'h2000_0000;

    localparam int MODE_USR_BIT = 1;
    localparam int MODE_HND_BIT = 2;

    typedef enum logic [2:0] {
        MODE_PRIV_THREAD = 3'h1,
        MODE_USER_THREAD = 3'h2,
        MODE_PRIV_HANDLER = 3'h4
    } cmr_mode_t;

    typedef enum logic [2:0] {
        FLT_NONE  = 3'h0,
        FLT_PRIV  = 3'h1,
        FLT_TBIT  = 3'h2,
        FLT_HIREG = 3'h3
    } cmr_fault_t;

endpackage : cmr_pkg

// [verif/cmr_core_regs_properties.sv]
// Checker for the core register block, watching top-level ports only.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/100ps

module cmr_core_regs_props
    import cmr_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_srst,
    input  wire logic [AW-1:0]    i_reg_addr,
    input  wire logic             i_reg_rd,
    input  wire logic             i_exc_entry,
    input  wire logic             i_exc_return,
    input  wire logic [EXC_W-1:0] i_exc_num,
    input  wire logic             i_irq_req,
    input  wire logic [EXC_W-1:0] i_irq_num,
    input  wire logic [15:0]      i_fetch_hw,
    input  wire logic             o_handler_mode,
    input  wire logic             o_user_level,
    input  wire logic             o_irq_take,
    input  wire logic             o_fault,
    input  wire logic [2:0]       o_fault_cause,
    input  wire logic             o_instr_wide
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    ////////////////////////////////////////////////////////////////////////
    a_handler_priv: assert property (o_handler_mode |-> !o_user_level)
        else $error("handler mode seen at user level");
    a_entry_handler: assert property (i_exc_entry |=> o_handler_mode)
        else $error("no handler mode after exception entry");
    a_handler_cause: assert property (
        $rose(o_handler_mode) |-> $past(i_exc_entry))
        else $error("handler mode entered without an exception");
    a_return_thread: assert property (
        i_exc_return && !i_exc_entry && i_exc_num == EXC_NONE
        |=> !o_handler_mode)
        else $error("handler mode kept after return to thread");
    a_user_fault: assert property (
        o_user_level && i_reg_rd && i_reg_addr == OFS_MASKALL
        |=> o_fault && o_fault_cause == 3'h1)
        else $error("user access to a mask register did not fault");
    a_nmi_taken: assert property (
        i_irq_req && i_irq_num == EXC_NMI |=> o_irq_take)
        else $error("nonmaskable request not taken");
    a_wide_decode: assert property (
        1'h1 |=> o_instr_wide == ($past(i_fetch_hw[15:13]) == WIDE_PFX
        && $past(i_fetch_hw[12:11]) != WIDE_NOT))
        else $error("wide encoding flag wrong");
    // Only an exception may drop user level; software cannot do it itself.
    a_user_holds: assert property (
        o_user_level && !i_exc_entry |=> o_user_level)
        else $error("user level left without an exception");
endmodule : cmr_core_regs_props

bind cmr_core_regs cmr_core_regs_props u_props (.*);

// [verif/tb.sv]
// Self-checking bench for the core register block: bus and core tasks.
// Assumes the design, package and checker are compiled before this file.
`timescale 1ns/100ps

module tb import cmr_pkg::*; ;
    logic i_ref_clk = 1'h0, i_srst = 1'h1, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
    logic i_rf_rd = 1'h0, i_rf_we = 1'h0, i_rf_narrow = 1'h0;
    logic i_rf_hi_ok = 1'h0, i_call = 1'h0, i_pc_load = 1'h0;
    logic i_pc_interwork = 1'h0, i_flags_we = 1'h0, i_exec_we = 1'h0;
    logic i_exc_entry = 1'h0, i_exc_return = 1'h0, i_irq_req = 1'h0;
    logic [AW-1:0] i_reg_addr = 8'h00;
    logic [XLEN-1:0] i_reg_wdata = 32'h0, i_rf_wdata = 32'h0;
    logic [XLEN-1:0] i_call_ret = 32'h0, i_pc_next = 32'h0, i_bb_addr = 32'h0;
    logic [3:0] i_rf_raddr = 4'h0, i_rf_waddr = 4'h0;
    logic [FLAG_W-1:0] i_flags = 5'h00;
    logic [EXEC_W-1:0] i_exec_state = 8'h00;
    logic [EXC_W-1:0] i_exc_num = 9'h0, i_irq_num = 9'h0, i_irq_prio = 9'h0;
    logic [15:0] i_fetch_hw = 16'h0;
    logic [XLEN-1:0] o_reg_rdata, o_rf_rdata, o_instr_pointer, o_bb_word_addr;
    logic o_handler_mode, o_user_level, o_irq_take, o_fault, o_instr_wide;
    logic o_bb_hit;
    logic [EXC_W-1:0] o_irq_take_num;
    logic [2:0] o_fault_cause;
    logic [4:0] o_bb_bit;
    int mismatches = 0;
    int check_count = 0;

    always #50 i_ref_clk = ~i_ref_clk;
    cmr_core_regs u_dut (.*);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [XLEN-1:0] got, input logic [XLEN-1:0] e);
        check_count++;
        if (got !== e)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, e);
        end
    endtask : chk
    // Every strobe drops at the next edge, so no request lasts two cycles.
    task automatic clr;
        @(posedge i_ref_clk);
        {i_reg_wr, i_reg_rd, i_call, i_pc_load, i_flags_we, i_exec_we,
         i_exc_entry, i_exc_return, i_irq_req, i_rf_rd, i_rf_we} <= 11'h0;
        #1;
    endtask : clr
    task automatic wr(input logic [AW-1:0] a, input logic [XLEN-1:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'h1;
        clr;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, input logic [XLEN-1:0] e);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'h1;
        clr;
        chk(o_reg_rdata, e);
    endtask : rd
    task automatic rfr(input logic [3:0] r, input logic h,
                       input logic [XLEN-1:0] e, input logic [3:0] f);
        @(posedge i_ref_clk);
        i_rf_raddr <= r;
        i_rf_hi_ok <= h;
        i_rf_narrow <= 1'h1;
        i_rf_rd <= 1'h1;
        clr;
        chk(o_rf_rdata, e);
        chk({o_fault, o_fault_cause}, f);
    endtask : rfr
    task automatic irq(input logic [8:0] n, p, input logic e);
        @(posedge i_ref_clk);
        i_irq_num <= n;
        i_irq_prio <= p;
        i_irq_req <= 1'h1;
        clr;
        chk(o_irq_take, e);
        chk(o_irq_take_num, n);
    endtask : irq
    task automatic exc(input logic en, input logic [EXC_W-1:0] n);
        @(posedge i_ref_clk);
        i_exc_num <= n;
        i_exc_entry <= en;
        i_exc_return <= !en;
        clr;
    endtask : exc
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        mismatches++;
        tally_and_finish;
    end
    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_srst <= 1'h0;
        rd(OFS_PSW, 32'h0100_0000);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_PRIOTHR, 32'h0);
        $display("test reset done");
        wr(8'h30, 32'hffff_fffe);
        rd(8'h30, 32'hffff_fffe);
        wr(8'h34, 32'h1234_5677);
        rd(8'h60, 32'h1234_5674);
        rfr(4'hc, 1'h0, 32'h0, 4'hb);
        rfr(4'hc, 1'h1, 32'hffff_fffe, 4'h0);
        rfr(4'hd, 1'h1, 32'h1234_5674, 4'h0);
        @(posedge i_ref_clk);
        i_rf_hi_ok <= 1'h0;
        i_rf_waddr <= 4'h9;
        i_rf_wdata <= 32'h5a5a_5a5a;
        i_rf_we <= 1'h1;
        clr;
        chk({o_fault, o_fault_cause}, 4'hb);
        rd(8'h24, 32'h0);
        $display("test core registers done");
        @(posedge i_ref_clk);
        i_call_ret <= 32'h0000_4321;
        i_call <= 1'h1;
        i_pc_next <= 32'h0000_1235;
        i_pc_load <= 1'h1;
        i_flags <= 5'h15;
        i_flags_we <= 1'h1;
        i_exec_state <= 8'hff;
        i_exec_we <= 1'h1;
        i_bb_addr <= 32'h2200_0084;
        i_fetch_hw <= 16'he800;
        clr;
        chk(o_instr_pointer, 32'h0000_1234);
        chk({o_bb_hit, o_bb_bit}, 6'h29);
        chk(o_bb_word_addr, 32'h2000_0000);
        chk(o_instr_wide, 1'h1);
        rd(8'h38, 32'h0000_4321);
        rd(OFS_PSW, 32'haf00_fc00);
        wr(OFS_EXEC, 32'h0);
        chk({o_fault, o_fault_cause}, 4'ha);
        rd(OFS_PSW, 32'haf00_fc00);
        @(posedge i_ref_clk);
        i_pc_next <= 32'h0000_2000;
        i_pc_interwork <= 1'h1;
        i_pc_load <= 1'h1;
        clr;
        chk({o_fault, o_fault_cause}, 4'ha);
        chk(o_instr_pointer, 32'h0000_2000);
        $display("test status word done");
        irq(9'h010, 9'h1ff, 1'h1);
        wr(OFS_PRIOTHR, 32'h4);
        irq(9'h010, 9'h004, 1'h0);
        irq(9'h010, 9'h003, 1'h1);
        wr(OFS_MASKALL, 32'h1);
        irq(9'h010, 9'h000, 1'h0);
        irq(EXC_HARD, 9'h000, 1'h1);
        wr(OFS_FLTMASK, 32'h1);
        irq(EXC_HARD, 9'h000, 1'h0);
        irq(EXC_NMI, 9'h000, 1'h1);
        $display("test masking done");
        wr(OFS_CTRL, 32'h3);
        chk(o_user_level, 1'h1);
        wr(8'h34, 32'h0000_8003);
        rd(8'h34, 32'h0000_8000);
        rd(OFS_MASKALL, 32'h0);
        chk({o_fault, o_fault_cause}, 4'h9);
        exc(1'h1, 9'h1ff);
        chk({o_handler_mode, o_user_level}, 2'h2);
        rd(8'h34, 32'h1234_5674);
        rd(8'h64, 32'h0000_8000);
        rd(OFS_EXCNUM, 32'h0000_01ff);
        exc(1'h0, EXC_NONE);
        chk({o_handler_mode, o_user_level}, 2'h1);
        exc(1'h1, EXC_HARD);
        wr(OFS_CTRL, 32'h2);
        rd(OFS_CTRL, 32'h0);
        $display("test modes done");
        tally_and_finish;
    end
endmodule : tb
